// [src/tpc_pkg.sv]
// Constants, types and register map of the pulse capture and event counter timer
//
// Function
// - Edge A captures counter into compare B
// - Edge needs two equal samples at new level
// - Dual-input mode: edge B captures into A
// - Separate two-bit edge fields per input
// - Opposite edge of A captures into A
// - Both-edges setting on A blocks opposite-edge capture into A
// - Restart mode: capture B, then clear counter
// - Restart mode: both edges block A capture
// - Event mode counts each valid A edge
// - Counter equals A: clear and raise irq
// - Event input sampled at half clock
// - Enable plus toggle bit: pin toggles on match
// - Edge codes: 00 fall, 01 rise, 11 both
// - Clock select: divides, external, ones prohibited
package tpc_pkg;

  // Widths
  localparam int CNT_W = 16; // Counter and compare width
  localparam int ADDR_W = 6; // Register address width
  localparam int DATA_W = 16; // Register data width
  localparam int DIV_W = 8; // Prescaler width

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_COUNTER = 6'h00; // up_counter, read only
  localparam logic [ADDR_W-1:0] ADDR_CCA = 6'h04; // capture_compare_a
  localparam logic [ADDR_W-1:0] ADDR_CCB = 6'h08; // capture_compare_b, read only
  localparam logic [ADDR_W-1:0] ADDR_MODE = 6'h0c; // timer_mode_reg
  localparam logic [ADDR_W-1:0] ADDR_CAPCTL = 6'h10; // capture_control_reg
  localparam logic [ADDR_W-1:0] ADDR_PRE_A = 6'h14; // prescale_edge_reg_a
  localparam logic [ADDR_W-1:0] ADDR_PRE_B = 6'h18; // prescale_reg_b
  localparam logic [ADDR_W-1:0] ADDR_OUTCTL = 6'h1c; // output_control_reg
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 6'h20; // Sticky events, read clears
  localparam logic [ADDR_W-1:0] ADDR_MASK = 6'h24; // Interrupt mask

  // Timer modes
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00, // Counter held at zero
    MODE_FREE = 2'b01, // Free-running
    MODE_RESTART = 2'b10, // Clear and restart on edge A
    MODE_MATCH = 2'b11 // Clear on match with compare A
  } mode_t;

  // Valid edge selections
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_NONE = 2'b10, // Prohibited code, detects nothing
    EDGE_BOTH = 2'b11
  } edge_t;

  // Count clock selections
  typedef enum logic [2:0] {
    CLK_DIV2 = 3'b000,
    CLK_DIV4 = 3'b001,
    CLK_DIV16 = 3'b010,
    CLK_EXT = 3'b011, // Valid edge of input A
    CLK_DIV32 = 3'b100,
    CLK_DIV128 = 3'b101,
    CLK_DIV256 = 3'b110,
    CLK_NONE = 3'b111 // Prohibited code, no count
  } clk_sel_t;

  // Prescaler masks: tick when all masked bits are ones
  localparam logic [DIV_W-1:0] MASK_DIV2 = 8'h01;
  localparam logic [DIV_W-1:0] MASK_DIV4 = 8'h03;
  localparam logic [DIV_W-1:0] MASK_DIV16 = 8'h0f;
  localparam logic [DIV_W-1:0] MASK_DIV32 = 8'h1f;
  localparam logic [DIV_W-1:0] MASK_DIV128 = 8'h7f;
  localparam logic [DIV_W-1:0] MASK_DIV256 = 8'hff;

  // Register layouts
  typedef struct packed {
    edge_t edge_b; // Bits 7:6, input B edge
    edge_t edge_a; // Bits 5:4, input A edge
    logic [1:0] rsv; // Bits 3:2, read as zero
    logic [1:0] clk_lo; // Bits 1:0, clock select low
  } prescale_a_t;

  typedef struct packed {
    logic opp_edge; // Bit 1, capture A on opposite edge of input A
    logic cca_capture; // Bit 0, compare A works as capture
  } cap_ctrl_t;

  typedef struct packed {
    logic match_toggle_bit; // Bit 1
    logic output_enable_bit; // Bit 0
  } out_ctrl_t;

  typedef struct packed {
    logic capture_b; // Bit 1
    logic match_a; // Bit 0, match or capture into A
  } irq_t;

  // Reset values and constants
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_STEP = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_STEP = 8'h01;
  localparam prescale_a_t PRE_A_RST = 8'h00;
  localparam cap_ctrl_t CAPCTL_RST = 2'h0;
  localparam out_ctrl_t OUTCTL_RST = 2'h0;
  localparam irq_t IRQ_RST = 2'h0;

endpackage : tpc_pkg

// [src/tpc_edge_filter.sv]
// Two-sample noise filter and valid edge detector for one capture input
`timescale 1ns/1ps
module tpc_edge_filter
  import tpc_pkg::*;
(
  input wire logic mclk, // Main clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic sample_i, // One-cycle sampling tick
  input wire logic pin_i, // Input level, synchronous
  input wire edge_t edge_sel_i, // Selected valid edge
  output logic valid_o, // Selected edge seen, pulse
  output logic opp_o // Opposite single edge seen, pulse
);

  logic last_q; // Previous sample
  logic stable_q; // Accepted filtered level
  logic change; // New level seen for the second time
  logic rise; // Accepted rising edge
  logic fall; // Accepted falling edge

  // Accept a change only on two equal samples at the new level
  assign change = sample_i && (pin_i == last_q) && (pin_i != stable_q);
  assign rise = change && pin_i;
  assign fall = change && !pin_i;

  // Edge field decode; the prohibited code yields nothing
  assign valid_o = (edge_sel_i == EDGE_RISE && rise) || (edge_sel_i == EDGE_FALL && fall) ||
                   (edge_sel_i == EDGE_BOTH && change);
  // No opposite edge exists when both edges are selected
  assign opp_o = (edge_sel_i == EDGE_RISE && fall) || (edge_sel_i == EDGE_FALL && rise);

  // Sample history and accepted level
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_q <= 1'b0;
      stable_q <= 1'b0;
    end
    else if (sample_i)
    begin
      last_q <= pin_i;
      stable_q <= change ? pin_i : stable_q;
    end
  end

  a_two_samples:
  assert property (@(posedge mclk) disable iff (!rst_n)
    (valid_o || opp_o) |-> (sample_i && pin_i == last_q && pin_i != stable_q) ##1 (stable_q == $past(pin_i)))
    else $error("Edge accepted without two samples");

  a_prohibited_edge:
  assert property (@(posedge mclk) disable iff (!rst_n)
    (edge_sel_i == EDGE_NONE) |-> !valid_o && !opp_o)
    else $error("Prohibited edge code detected an edge");

endmodule : tpc_edge_filter

// [src/timer_pulse_capture_event_count.sv]
// 16-bit timer with pulse capture, event counting and square wave output
`timescale 1ns/1ps
module timer_pulse_capture_event_count
  import tpc_pkg::*;
(
  input wire logic mclk, // Main clock, 250 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] addr, // Register byte address
  input wire logic [DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [DATA_W-1:0] rdata, // Read data, cycle after strobe
  input wire logic capture_input_a, // First capture or event input
  input wire logic capture_input_b, // Second capture input
  output logic timer_output_pin, // Square wave output
  output logic match_a_irq, // Match or capture into A, pulse
  output logic capture_b_irq, // Capture into B, pulse
  output logic irq // Level interrupt, unmasked status set
);

  // Register state
  logic [CNT_W-1:0] cnt_q; // up_counter
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cca_q; // capture_compare_a
  logic [CNT_W-1:0] cca_d;
  logic [CNT_W-1:0] ccb_q; // capture_compare_b
  logic [CNT_W-1:0] ccb_d;
  mode_t mode_q; // timer_mode_reg
  cap_ctrl_t capctl_q; // capture_control_reg
  prescale_a_t pre_a_q; // prescale_edge_reg_a
  logic pre_b_q; // prescale_reg_b, clock select high bit
  out_ctrl_t outctl_q; // output_control_reg
  irq_t status_q; // Sticky event status
  irq_t status_d;
  irq_t mask_q; // Interrupt mask
  logic [DIV_W-1:0] div_q; // Prescaler counter
  logic [DATA_W-1:0] rdata_q; // Read data register
  logic tout_q; // Output pin level
  logic tout_d;
  logic match_irq_q; // Pulse towards interrupt controller
  logic capb_irq_q; // Pulse towards interrupt controller

  // Decoded controls
  logic run; // Timer not stopped
  clk_sel_t clk_sel; // Assembled clock select
  logic ext_clk; // Counting edges of input A
  logic [DIV_W-1:0] div_mask; // Prescaler tick mask
  logic pre_tick; // Internal count clock tick
  logic half_tick; // Main clock over two
  logic sample; // Filter sampling tick
  logic cnt_tick; // Counter advance tick
  logic evt_a; // Valid edge on input A
  logic opp_a; // Opposite edge on input A
  logic evt_b; // Valid edge on input B
  logic cap_b_trig; // Load compare B
  logic cap_a_trig; // Load compare A as capture
  logic restart_clr; // Clear on restart edge
  logic match_a; // Counter matched compare A
  logic wr_cca; // Software write to compare A
  logic rd_status; // Software read of status
  logic [DATA_W-1:0] rd_mux; // Read selection

  // Clock select: low bits in register A, high bit in register B
  assign clk_sel = clk_sel_t'({pre_b_q, pre_a_q.clk_lo});
  assign run = (mode_q != MODE_STOP);
  assign ext_clk = (clk_sel == CLK_EXT);

  // Prescaler tap mask per clock selection
  always_comb
  begin
    case (clk_sel)
      CLK_DIV2: div_mask = MASK_DIV2;
      CLK_DIV4: div_mask = MASK_DIV4;
      CLK_DIV16: div_mask = MASK_DIV16;
      CLK_DIV32: div_mask = MASK_DIV32;
      CLK_DIV128: div_mask = MASK_DIV128;
      CLK_DIV256: div_mask = MASK_DIV256;
      default: div_mask = MASK_DIV2; // External and prohibited: unused
    endcase
  end

  // Ticks; prohibited selection never counts
  assign half_tick = run && ((div_q & MASK_DIV2) == MASK_DIV2);
  assign pre_tick = run && !ext_clk && (clk_sel != CLK_NONE) && ((div_q & div_mask) == div_mask);
  // External clock mode samples at half the main clock
  assign sample = ext_clk ? half_tick : pre_tick;
  assign cnt_tick = ext_clk ? evt_a : pre_tick;

  // Noise filters, one per capture input, each with its own edge field
  tpc_edge_filter u_filt_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .sample_i(sample),
    .pin_i(capture_input_a),
    .edge_sel_i(pre_a_q.edge_a),
    .valid_o(evt_a),
    .opp_o(opp_a)
  );

  tpc_edge_filter u_filt_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .sample_i(sample),
    .pin_i(capture_input_b),
    .edge_sel_i(pre_a_q.edge_b),
    .valid_o(evt_b),
    .opp_o()
  );

  // Capture triggers; opposite edge is absent when both edges selected
  assign cap_b_trig = evt_a && !ext_clk && (mode_q == MODE_FREE || mode_q == MODE_RESTART);
  assign cap_a_trig = capctl_q.cca_capture && !ext_clk &&
                      (capctl_q.opp_edge ? (opp_a && (mode_q == MODE_FREE || mode_q == MODE_RESTART))
                                         : (evt_b && mode_q == MODE_FREE));
  assign restart_clr = cap_b_trig && (mode_q == MODE_RESTART);
  assign match_a = (mode_q == MODE_MATCH) && !capctl_q.cca_capture && cnt_tick && (cnt_q == cca_q);

  // Counter: cleared on stop, restart edge or match, else wraps
  assign cnt_d = !run ? CNT_ZERO :
                 !cnt_tick ? cnt_q :
                 (restart_clr || match_a) ? CNT_ZERO :
                 cnt_q + CNT_STEP;

  // Compare registers; a capture wins over a software write
  assign wr_cca = wr && (addr == ADDR_CCA);
  assign cca_d = cap_a_trig ? cnt_q : (wr_cca ? wdata[CNT_W-1:0] : cca_q);
  assign ccb_d = cap_b_trig ? cnt_q : ccb_q;

  // Square wave: toggle on each match while enabled and toggle bit set
  assign tout_d = !outctl_q.output_enable_bit ? 1'b0 :
                  (outctl_q.match_toggle_bit && match_a) ? !tout_q : tout_q;

  // Status: read clears, a same-cycle event still sets
  assign rd_status = rd && (addr == ADDR_STATUS);
  assign status_d = (rd_status ? IRQ_RST : status_q) | irq_t'({cap_b_trig, match_a || cap_a_trig});

  // Read selection; counter holds the event count
  always_comb
  begin
    case (addr)
      ADDR_COUNTER: rd_mux = cnt_q;
      ADDR_CCA: rd_mux = cca_q;
      ADDR_CCB: rd_mux = ccb_q;
      ADDR_MODE: rd_mux = {14'h0000, mode_q};
      ADDR_CAPCTL: rd_mux = {14'h0000, capctl_q};
      ADDR_PRE_A: rd_mux = {8'h00, pre_a_q.edge_b, pre_a_q.edge_a, 2'h0, pre_a_q.clk_lo};
      ADDR_PRE_B: rd_mux = {15'h0000, pre_b_q};
      ADDR_OUTCTL: rd_mux = {14'h0000, outctl_q};
      ADDR_STATUS: rd_mux = {14'h0000, status_q};
      ADDR_MASK: rd_mux = {14'h0000, mask_q};
      default: rd_mux = 16'h0000; // Unmapped reads zero
    endcase
  end

  // Counter, prescaler and capture registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= CNT_ZERO;
      cca_q <= CNT_ZERO;
      ccb_q <= CNT_ZERO;
      div_q <= DIV_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
      cca_q <= cca_d;
      ccb_q <= ccb_d;
      div_q <= run ? div_q + DIV_STEP : DIV_ZERO;
    end
  end

  // Control registers; prescaler written in any mode, also while running
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= MODE_STOP;
      capctl_q <= CAPCTL_RST;
      pre_a_q <= PRE_A_RST;
      pre_b_q <= 1'b0;
      outctl_q <= OUTCTL_RST;
      mask_q <= IRQ_RST;
    end
    else if (wr)
    begin
      case (addr)
        ADDR_MODE: mode_q <= mode_t'(wdata[1:0]);
        ADDR_CAPCTL: capctl_q <= cap_ctrl_t'(wdata[1:0]);
        ADDR_PRE_A: pre_a_q <= prescale_a_t'({wdata[7:4], 2'h0, wdata[1:0]});
        ADDR_PRE_B: pre_b_q <= wdata[0];
        ADDR_OUTCTL: outctl_q <= out_ctrl_t'(wdata[1:0]);
        ADDR_MASK: mask_q <= irq_t'(wdata[1:0]);
        default: mode_q <= mode_q; // Compare A written elsewhere, read-only or unmapped
      endcase
    end
  end

  // Output pin, interrupt pulses, status and read data
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tout_q <= 1'b0;
      match_irq_q <= 1'b0;
      capb_irq_q <= 1'b0;
      status_q <= IRQ_RST;
      rdata_q <= 16'h0000;
    end
    else
    begin
      tout_q <= tout_d;
      match_irq_q <= match_a || cap_a_trig;
      capb_irq_q <= cap_b_trig;
      status_q <= status_d;
      rdata_q <= rd ? rd_mux : 16'h0000;
    end
  end

  assign timer_output_pin = tout_q;
  assign match_a_irq = match_irq_q;
  assign capture_b_irq = capb_irq_q;
  assign rdata = rdata_q;
  assign irq = |(status_q & mask_q);

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_cap_b_load:
  assert property ((mode_q == MODE_FREE && evt_a && !ext_clk) |=> (ccb_q == $past(cnt_q)) && capture_b_irq)
    else $error("Edge A did not capture into B");

  a_cap_a_from_b:
  assert property ((mode_q == MODE_FREE && capctl_q == 2'b01 && evt_b && !ext_clk)
                   |=> (cca_q == $past(cnt_q)) && match_a_irq)
    else $error("Edge B did not capture into A");

  a_opp_capture:
  assert property ((mode_q == MODE_FREE && capctl_q == 2'b11 && opp_a && !ext_clk) |=> cca_q == $past(cnt_q))
    else $error("Opposite edge did not capture into A");

  a_both_blocks:
  assert property ((capctl_q.opp_edge && pre_a_q.edge_a == EDGE_BOTH && !wr_cca) |=> $stable(cca_q))
    else $error("Compare A captured with both edges selected");

  a_restart_clear:
  assert property ((mode_q == MODE_RESTART && evt_a && !ext_clk)
                   |=> (cnt_q == CNT_ZERO) && (ccb_q == $past(cnt_q)))
    else $error("Restart edge did not capture and clear");

  a_event_count:
  assert property ((mode_q == MODE_MATCH && ext_clk && evt_a && cnt_q != cca_q) |=> cnt_q == $past(cnt_q) + CNT_STEP)
    else $error("Event did not advance counter");

  a_match_clear:
  assert property (match_a |=> (cnt_q == CNT_ZERO) && match_a_irq && status_q.match_a)
    else $error("Match did not clear and interrupt");

  a_event_sample:
  assert property ((ext_clk && sample) |=> !sample ##1 (sample || !run || !ext_clk))
    else $error("Event input not sampled at half rate");

  a_square_toggle:
  assert property ((match_a && outctl_q == 2'b11) |=> tout_q != $past(tout_q))
    else $error("Output pin did not toggle on match");

  a_no_clock:
  assert property ((clk_sel == CLK_NONE) |=> $stable(cnt_q))
    else $error("Prohibited clock select advanced counter");

  a_free_wrap:
  assert property ((mode_q == MODE_FREE && cnt_tick && cnt_q == CNT_MAX && !wr) |=> cnt_q == CNT_ZERO)
    else $error("Free-running counter did not wrap");

  a_irq_pulse:
  assert property (capture_b_irq |-> ($past(cap_b_trig) && ccb_q == $past(cnt_q)) ##1 !capture_b_irq)
    else $error("Capture interrupt not a single pulse");

endmodule : timer_pulse_capture_event_count

// [testbench/tpc_pulse_src.sv]
// Behavioural source of pulse and event levels on the two capture inputs
`timescale 1ns/1ps
module tpc_pulse_src (
  input wire logic mclk, // Main clock
  output logic pin_a, // Level for capture_input_a
  output logic pin_b // Level for capture_input_b
);
  // Both lines idle low from time zero
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // One high pulse on a pin, changed just after an edge; short pulses act as noise
  task automatic pulse(input bit sel_b, input int hi, input int lo);
    @(posedge mclk);
    if (sel_b)
      pin_b <= 1'b1;
    else
      pin_a <= 1'b1;
    repeat (hi) @(posedge mclk);
    if (sel_b)
      pin_b <= 1'b0;
    else
      pin_a <= 1'b0;
    repeat (lo) @(posedge mclk);
  endtask : pulse
endmodule : tpc_pulse_src

// [testbench/timer_pulse_capture_event_count_tb.sv]
// Self-checking bench for the pulse capture and event counter timer
`timescale 1ns/1ps
module timer_pulse_capture_event_count_tb;
  import tpc_pkg::*;
  logic mclk = 1'b0; // Main clock
  logic rst_n = 1'b0; // Reset, active low
  logic [ADDR_W-1:0] addr = '0; // Bus address
  logic [DATA_W-1:0] wdata = '0; // Bus write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [DATA_W-1:0] rdata; // Read data
  logic in_a; // Source level on input A
  logic in_b; // Source level on input B
  logic pin; // Square wave output
  logic m_irq; // Match or capture A pulse
  logic b_irq; // Capture B pulse
  logic irq; // Level interrupt
  int err_total = 0; // Mismatches
  int cmp_count = 0; // Comparisons
  int n_a = 0; // Pulses seen on match_a_irq
  int n_b = 0; // Pulses seen on capture_b_irq
  logic rd_q = 1'b0; // Read taken last edge
  logic [DATA_W-1:0] last_rd = '0; // Latest read data
  logic [DATA_W-1:0] exp_q[$]; // Expected read data, oldest first
  bit chk_q[$]; // Whether each read is compared

  // 250 MHz clock
  initial
  begin
    forever #2 mclk = ~mclk;
  end

  timer_pulse_capture_event_count DUT (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .capture_input_a(in_a), .capture_input_b(in_b), .timer_output_pin(pin),
    .match_a_irq(m_irq), .capture_b_irq(b_irq), .irq(irq)
  );

  tpc_pulse_src src (.mclk(mclk), .pin_a(in_a), .pin_b(in_b));

  // Compare one value and count it
  task automatic cmp(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // Monitor: pulse counts, and read data against the oldest note
  always @(posedge mclk)
  begin
    rd_q <= rd;
    if (m_irq === 1'b1)
      n_a <= n_a + 1;
    if (b_irq === 1'b1)
      n_b <= n_b + 1;
    if (rd_q && exp_q.size() > 0)
    begin
      last_rd = rdata;
      if (chk_q.pop_front())
        cmp("rdata", exp_q.pop_front(), rdata);
      else
        void'(exp_q.pop_front());
    end
  end

  // One strobe cycle, then wait until the read data have been taken
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [DATA_W-1:0] e, input bit c);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w)
    begin
      exp_q.push_back(e);
      chk_q.push_back(c);
    end
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : bus

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d, 16'h0000, 1'b0);
  endtask : wreg

  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b0, a, 16'h0000, e, 1'b1);
  endtask : rreg

  // Stop, program prescaler and edges, then start in a mode
  task automatic setup(input logic [DATA_W-1:0] pre_a, input logic [DATA_W-1:0] pre_b,
                       input logic [DATA_W-1:0] cap, input logic [DATA_W-1:0] mode);
    wreg(ADDR_MODE, 16'h0000);
    wreg(ADDR_PRE_A, pre_a);
    wreg(ADDR_PRE_B, pre_b);
    wreg(ADDR_CAPCTL, cap);
    wreg(ADDR_MODE, mode);
  endtask : setup

  // Print counts and verdict, end the run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Watchdog against a hang
  initial
  begin
    repeat (100000) @(posedge mclk);
    err_total++;
    summarize();
  end

  // Main sequence
  initial
  begin
    int h;
    int n;
    int a0;
    int b0;
    int dv;
    int ev;
    logic [DATA_W-1:0] c0;
    logic [DATA_W-1:0] c1;
    int divs[8];
    int exp_b[4];
    divs = '{2, 4, 16, 0, 32, 128, 256, 0};
    exp_b = '{1, 1, 0, 2};
    void'($urandom(32'h8e568b8e));
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, last address unmapped
    for (int i = 0; i < 11; i++)
      rreg(6'(i * 4), 16'h0000);
    wreg(ADDR_CCB, 16'h1234);
    rreg(ADDR_CCB, 16'h0000);
    wreg(ADDR_CCA, 16'ha5c3);
    rreg(ADDR_CCA, 16'ha5c3);
    // Free run, rise into B, fall into A, random width
    wreg(ADDR_MASK, 16'h0003);
    setup(16'h0010, 16'h0000, 16'h0003, 16'h0001);
    h = 2 * (4 + int'($urandom % 20));
    src.pulse(1'b0, h, 8);
    repeat (8) @(posedge mclk);
    bus(1'b0, ADDR_CCB, 16'h0000, 16'h0000, 1'b0);
    c0 = last_rd;
    bus(1'b0, ADDR_CCA, 16'h0000, 16'h0000, 1'b0);
    c1 = last_rd;
    cmp("pulse width", 16'(h / 2), c1 - c0);
    cmp("capture b pulses", 16'h0001, 16'(n_b));
    cmp("capture a pulses", 16'h0001, 16'(n_a));
    cmp("irq set", 16'h0001, 16'(irq));
    rreg(ADDR_STATUS, 16'h0003);
    cmp("irq cleared", 16'h0000, 16'(irq));
    // Noise shorter than two samples
    src.pulse(1'b0, 2, 8);
    repeat (8) @(posedge mclk);
    cmp("noise ignored", 16'h0001, 16'(n_b));
    // Dual input: every edge code on input B
    for (int e = 0; e < 4; e++)
    begin
      setup(16'((e << 6) | 16'h0010), 16'h0000, 16'h0001, 16'h0001);
      a0 = n_a;
      src.pulse(1'b1, 8, 8);
      repeat (8) @(posedge mclk);
      cmp("edge b captures", 16'(exp_b[e]), 16'(n_a - a0));
    end
    wreg(ADDR_MASK, 16'h0002);
    cmp("irq masked", 16'h0000, 16'(irq));
    rreg(ADDR_STATUS, 16'h0001);
    // Both edges on A: no capture into A
    setup(16'h0030, 16'h0000, 16'h0003, 16'h0001);
    a0 = n_a;
    b0 = n_b;
    src.pulse(1'b0, 8, 8);
    repeat (8) @(posedge mclk);
    cmp("both edges into b", 16'h0002, 16'(n_b - b0));
    cmp("no capture into a", 16'h0000, 16'(n_a - a0));
    // Restart mode: equal spacing gives equal captures
    setup(16'h0010, 16'h0000, 16'h0000, 16'h0002);
    src.pulse(1'b0, 8, 31);
    src.pulse(1'b0, 8, 31);
    bus(1'b0, ADDR_CCB, 16'h0000, 16'h0000, 1'b0);
    c0 = last_rd;
    src.pulse(1'b0, 8, 31);
    src.pulse(1'b0, 8, 31);
    bus(1'b0, ADDR_CCB, 16'h0000, 16'h0000, 1'b0);
    cmp("restart capture", c0, last_rd);
    cmp("restart span", 16'h0001, 16'(c0 == 16'd19 || c0 == 16'd20));
    // Restart with both edges on A: compare A never captures
    setup(16'h0030, 16'h0000, 16'h0003, 16'h0002);
    a0 = n_a;
    src.pulse(1'b0, 8, 8);
    repeat (8) @(posedge mclk);
    cmp("restart both edges", 16'h0000, 16'(n_a - a0));
    // Event counter with clear on match and toggling pin
    n = 2 + int'($urandom % 4);
    wreg(ADDR_CCA, 16'(n));
    wreg(ADDR_OUTCTL, 16'h0003);
    setup(16'h0013, 16'h0000, 16'h0000, 16'h0003);
    repeat (n) src.pulse(1'b0, 4, 4);
    repeat (8) @(posedge mclk);
    rreg(ADDR_COUNTER, 16'(n));
    a0 = n_a;
    src.pulse(1'b0, 4, 4);
    repeat (8) @(posedge mclk);
    rreg(ADDR_COUNTER, 16'h0000);
    cmp("match pulse", 16'h0001, 16'(n_a - a0));
    cmp("output toggled", 16'h0001, 16'(pin));
    src.pulse(1'b0, 4, 4);
    src.pulse(1'b0, 2, 6);
    src.pulse(1'b0, 4, 4);
    repeat (8) @(posedge mclk);
    rreg(ADDR_COUNTER, 16'h0002);
    // Every internal clock select, prohibited code counts nothing
    wreg(ADDR_OUTCTL, 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      if (k == 3)
        continue;
      setup(16'(k & 3), 16'(k >> 2), 16'h0000, 16'h0001);
      repeat (1024) @(posedge mclk);
      bus(1'b0, ADDR_COUNTER, 16'h0000, 16'h0000, 1'b0);
      dv = divs[k];
      ev = (dv == 0) ? 0 : 1027 / dv;
      cmp("count rate", 16'h0001, 16'((int'(last_rd) - ev) <= 2 && (ev - int'(last_rd)) <= 2));
    end
    summarize();
  end
endmodule : timer_pulse_capture_event_count_tb
